// [verilog/adc_pkg.sv]
package adc_pkg;
  // bus geometry
  localparam int DATA_W = 32;
  localparam int OFS_W = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // register byte offsets
  localparam logic [OFS_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [OFS_W-1:0] STAT_OFS = 12'h004;
  localparam logic [OFS_W-1:0] IRQ_STAT_OFS = 12'h008;
  localparam logic [OFS_W-1:0] IRQ_MASK_OFS = 12'h00C;
  localparam logic [OFS_W-1:0] RES_BASE_OFS = 12'h040;

  // control word fields
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_RC_BIT = 1;
  localparam int CTRL_SIDL_BIT = 2;
  localparam int CTRL_FORM_LSB = 4;
  localparam int CTRL_START_BIT = 8;

  // status word fields
  localparam int ST_CONVERSION_IN_PROGRESS_BIT = 0;
  localparam int ST_PWR_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_IDLE_BIT = 3;
  localparam int ST_AUTOOFF_BIT = 4;

  // interrupt word fields
  localparam int IRQ_DONE_BIT = 0;

  // result geometry
  localparam int RES_W = 12;
  localparam int RES_DEPTH = 16;

  // timing, ns and derived cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int INSTR_NS = 20;
  localparam int CONVERSION_IN_PROGRESS_NS = 700;
  localparam int INSTR_CYC = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONVERSION_IN_PROGRESS_CYC = (CONVERSION_IN_PROGRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    FMT_UINT = 2'h0,
    FMT_SINT = 2'h1,
    FMT_UFRAC = 2'h2,
    FMT_SFRAC = 2'h3
  } fmt_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'h0,
    CS_DELAY = 2'h1,
    CS_CONVERSION_IN_PROGRESS = 2'h3
  } conversion_in_progress_state_t;
endpackage

// [verilog/conversion_in_progress_if.sv]
interface conversion_in_progress_if;
  import adc_pkg::*;
  logic start;
  logic abort;
  logic rc_mode;
  logic clk_run;
  logic [RES_W-1:0] sample;
  logic busy;
  logic done;
  logic [RES_W-1:0] result;
  modport ctrl (output start, abort, rc_mode, clk_run, sample, input busy, done, result);
  modport core (input start, abort, rc_mode, clk_run, sample, output busy, done, result);
endinterface

// [verilog/adc_conversion_in_progress_core.sv]
module adc_conversion_in_progress_core #(
  parameter int CONVERSION_IN_PROGRESS_CYCLES = adc_pkg::CONVERSION_IN_PROGRESS_CYC,
  parameter int DELAY_CYCLES = adc_pkg::INSTR_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  conversion_in_progress_if.core cif
);
  import adc_pkg::*;

  conversion_in_progress_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic done_q;
  logic [RES_W-1:0] result_q;

  assign cif.busy = (state_q != CS_IDLE);
  assign cif.done = done_q;
  assign cif.result = result_q;

  // sequencer; abort wins over everything so a partial conversion never resumes
  always_ff @(posedge ref_clk) begin
    done_q <= 1'b0;
    if (rst || cif.abort) begin
      state_q <= CS_IDLE; // [RULE_05] [RULE_12]
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        CS_IDLE: begin
          if (cif.start && cif.rc_mode) begin
            state_q <= CS_DELAY; // [RULE_07]
            cnt_q <= CNT_W'(DELAY_CYCLES - 1);
          end else if (cif.start) begin
            state_q <= CS_CONVERSION_IN_PROGRESS;
            cnt_q <= CNT_W'(CONVERSION_IN_PROGRESS_CYCLES - 1);
          end
        end
        CS_DELAY: begin
          if (cif.clk_run && cnt_q == '0) begin
            state_q <= CS_CONVERSION_IN_PROGRESS;
            cnt_q <= CNT_W'(CONVERSION_IN_PROGRESS_CYCLES - 1);
          end else if (cif.clk_run) begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        CS_CONVERSION_IN_PROGRESS: begin
          if (cif.clk_run && cnt_q == '0) begin
            state_q <= CS_IDLE;
            done_q <= 1'b1; // [RULE_08]
          end else if (cif.clk_run) begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  // result captured at the end of the conversion window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_q <= '0;
    end else if (state_q == CS_CONVERSION_IN_PROGRESS && cif.clk_run && cnt_q == '0 && !cif.abort) begin
      result_q <= cif.sample; // [RULE_14]
    end
  end

  rc_delay_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_07]
    state_q == CS_IDLE && cif.start && cif.rc_mode && !cif.abort |=> state_q == CS_DELAY)
    else $error("rc start did not enter delay");
  abort_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_05]
    cif.abort |=> !cif.busy && !cif.done)
    else $error("abort left sequencer busy");
endmodule

// [verilog/adc_power_ctrl.sv]
// Function
// [RULE_01] converter on means powered and converting
// [RULE_02] converter off disables digital and analog
// [RULE_03] software waits for settling after power-up
// [RULE_04] sleep stops converter clocks, held low
// [RULE_05] sleep aborts conversion, never resumed
// [RULE_06] sleep entry and exit keep registers
// [RULE_07] rc clock runs in sleep, delayed start
// [RULE_08] completion clears busy bit, stores result
// [RULE_09] enabled interrupt on completion wakes sleep
// [RULE_10] masked completion in sleep powers off silently
// [RULE_11] idle halts only when stop-in-idle set
// [RULE_12] reset clears registers, converter off, aborts
// [RULE_13] reset leaves result buffer untouched
// [RULE_14] results and buffer entries are twelve bits
// [RULE_15] two-bit format field selects read format
// [RULE_16] integer right-justified, fractional left-justified
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
module adc_power_ctrl #(
  parameter int DEPTH = adc_pkg::RES_DEPTH,
  parameter int CONVERSION_IN_PROGRESS_CYCLES = adc_pkg::CONVERSION_IN_PROGRESS_CYC,
  parameter int DELAY_CYCLES = adc_pkg::INSTR_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [adc_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [adc_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic [adc_pkg::RES_W-1:0] analog_code,
  output logic analog_pwr_en,
  output logic conversion_in_progress_clk_en,
  output logic wake_req,
  output logic irq
);
  import adc_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [OFS_W-1:0] RES_END_OFS = RES_BASE_OFS + OFS_W'(4 * DEPTH);

  conversion_in_progress_if cif();

  logic on_q, rc_q, sidl_q;
  fmt_t form_q;
  logic conversion_in_progress_q, auto_off_q, start_q;
  logic done_flag_q, done_mask_q;
  logic wr_pend_q;
  logic [OFS_W-1:0] wr_ofs_q;
  logic [RES_W-1:0] sync1_q, sync2_q;
  logic [RES_W-1:0] buf_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [DATA_W-1:0] rd_word;
  logic [OFS_W-1:0] acc_ofs;
  logic [OFS_W-1:0] res_rel;
  logic [PTR_W-1:0] rd_idx;
  logic accept, halt, ctrl_wr, start_ok, done_w1c, mask_wr;
  logic hreadyout_q, hresp_q, pwr_q, clk_q, wake_q, irq_q;
  logic [DATA_W-1:0] hrdata_q;

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign analog_pwr_en = pwr_q;
  assign conversion_in_progress_clk_en = clk_q;
  assign wake_req = wake_q;
  assign irq = irq_q;

  // bus decode and halting conditions
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
  assign acc_ofs = haddr[OFS_W-1:0];
  assign res_rel = acc_ofs - RES_BASE_OFS;
  assign rd_idx = PTR_W'(res_rel >> 2);
  assign halt = (sleep_mode && !rc_q) || (idle_mode && sidl_q); // [RULE_04] [RULE_11]
  assign ctrl_wr = wr_pend_q && wr_ofs_q == CTRL_OFS;
  assign mask_wr = wr_pend_q && wr_ofs_q == IRQ_MASK_OFS;
  assign done_w1c = wr_pend_q && wr_ofs_q == IRQ_STAT_OFS && hwdata[IRQ_DONE_BIT];
  // a start request is dropped while off, halted or busy, software sees it via the status bit;
  // a standing abort would keep the busy bit low while the core still launched, so it blocks the start
  assign start_ok = ctrl_wr && hwdata[CTRL_START_BIT] && hwdata[CTRL_ON_BIT] && !conversion_in_progress_q && !cif.busy && !cif.abort;

  // core hookup; off, auto-off and halts abort any sequence in flight
  assign cif.start = start_q;
  assign cif.rc_mode = rc_q; // [RULE_07]
  assign cif.clk_run = on_q && !auto_off_q && !halt;
  assign cif.abort = !on_q || auto_off_q || halt; // [RULE_02] [RULE_05] [RULE_11]
  assign cif.sample = sync2_q;

  adc_conversion_in_progress_core #(
    .CONVERSION_IN_PROGRESS_CYCLES(CONVERSION_IN_PROGRESS_CYCLES),
    .DELAY_CYCLES(DELAY_CYCLES)
  ) u_core (
    .ref_clk(ref_clk),
    .rst(rst),
    .cif(cif)
  );

  // analog code crosses in from the pin through two flops
  always_ff @(posedge ref_clk) begin
    sync1_q <= analog_code;
    sync2_q <= sync1_q;
  end

  // bus address phase capture; zero wait states, always okay
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= '0;
      hrdata_q <= '0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= accept && hwrite;
      wr_ofs_q <= acc_ofs;
      hrdata_q <= (accept && !hwrite) ? rd_word : '0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // control word; only bus writes change it, never sleep or idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      on_q <= 1'b0; // [RULE_12]
      rc_q <= 1'b0;
      sidl_q <= 1'b0;
      form_q <= FMT_UINT;
    end else if (ctrl_wr) begin
      on_q <= hwdata[CTRL_ON_BIT]; // [RULE_06]
      rc_q <= hwdata[CTRL_RC_BIT];
      sidl_q <= hwdata[CTRL_SIDL_BIT];
      form_q <= fmt_t'(hwdata[CTRL_FORM_LSB +: 2]); // [RULE_15]
    end
  end

  // conversion-in-progress bit; start wins only when nothing clears it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conversion_in_progress_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= start_ok;
      if (cif.done || cif.abort) begin
        conversion_in_progress_q <= 1'b0; // [RULE_08] [RULE_05]
      end else if (start_ok) begin
        conversion_in_progress_q <= 1'b1;
      end
    end
  end

  // silent power-down after a masked completion in sleep, until control is rewritten
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      auto_off_q <= 1'b0;
    end else if (cif.done && sleep_mode && !done_mask_q) begin
      auto_off_q <= 1'b1; // [RULE_10]
    end else if (ctrl_wr) begin
      auto_off_q <= 1'b0;
    end
  end

  // power and clock gating outputs; clocks held low in sleep unless rc selected
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      pwr_q <= on_q && !auto_off_q; // [RULE_01] [RULE_02]
      clk_q <= on_q && !auto_off_q && !halt; // [RULE_04] [RULE_11]
    end
  end

  // sticky done flag, set beats write-one-to-clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_flag_q <= 1'b0;
      done_mask_q <= 1'b0;
    end else begin
      done_flag_q <= cif.done || (done_flag_q && !done_w1c);
      if (mask_wr) begin
        done_mask_q <= hwdata[IRQ_DONE_BIT];
      end
    end
  end

  // interrupt level and sleep wake pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= done_flag_q && done_mask_q;
      wake_q <= cif.done && sleep_mode && done_mask_q; // [RULE_09]
    end
  end

  // write pointer is control state; buffer itself has no reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
    end else if (cif.done) begin
      wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
  end

  // contents survive reset, undefined after power-up
  always_ff @(posedge ref_clk) begin
    if (cif.done) begin
      buf_mem[wr_ptr_q] <= cif.result; // [RULE_13] [RULE_14]
    end
  end

  // offset-binary code; signed forms invert the top bit
  function automatic logic [15:0] format_word(input fmt_t f, input logic [RES_W-1:0] r);
    logic [RES_W-1:0] s;
    s = {~r[RES_W-1], r[RES_W-2:0]};
    unique case (f)
      FMT_UINT: format_word = {4'h0, r}; // [RULE_16]
      FMT_SINT: format_word = {{4{s[RES_W-1]}}, s}; // [RULE_16]
      FMT_UFRAC: format_word = {r, 4'h0}; // [RULE_16]
      FMT_SFRAC: format_word = {s, 4'h0}; // [RULE_16]
    endcase
  endfunction

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    if (acc_ofs == CTRL_OFS) begin
      rd_word[CTRL_ON_BIT] = on_q; // [RULE_10]
      rd_word[CTRL_RC_BIT] = rc_q;
      rd_word[CTRL_SIDL_BIT] = sidl_q;
      rd_word[CTRL_FORM_LSB +: 2] = form_q;
    end else if (acc_ofs == STAT_OFS) begin
      rd_word[ST_CONVERSION_IN_PROGRESS_BIT] = conversion_in_progress_q;
      rd_word[ST_PWR_BIT] = pwr_q;
      rd_word[ST_SLEEP_BIT] = sleep_mode;
      rd_word[ST_IDLE_BIT] = idle_mode;
      rd_word[ST_AUTOOFF_BIT] = auto_off_q;
    end else if (acc_ofs == IRQ_STAT_OFS) begin
      rd_word[IRQ_DONE_BIT] = done_flag_q;
    end else if (acc_ofs == IRQ_MASK_OFS) begin
      rd_word[IRQ_DONE_BIT] = done_mask_q;
    end else if (acc_ofs >= RES_BASE_OFS && acc_ofs < RES_END_OFS && acc_ofs[1:0] == 2'h0) begin
      rd_word[15:0] = format_word(form_q, buf_mem[rd_idx]); // [RULE_15]
    end
  end

  // power follows the control state one edge later, so a later auto-off may not trip it
  pwr_follow_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_01]
    on_q && !auto_off_q && !ctrl_wr |=> analog_pwr_en)
    else $error("converter on but not powered");
  off_state_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_02]
    !on_q && !ctrl_wr |=> !analog_pwr_en && !conversion_in_progress_clk_en && !conversion_in_progress_q)
    else $error("converter off but active");
  sleep_clk_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_04]
    sleep_mode && !rc_q |=> !conversion_in_progress_clk_en)
    else $error("clock running in sleep");
  sleep_abort_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_05]
    sleep_mode && !rc_q && conversion_in_progress_q |=> !conversion_in_progress_q && !cif.busy)
    else $error("conversion survived sleep");
  sleep_regs_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_06]
    $changed(sleep_mode) && !ctrl_wr |=> $stable(on_q) && $stable(rc_q) && $stable(form_q))
    else $error("sleep changed control");
  done_store_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_08]
    cif.done |=> !conversion_in_progress_q && buf_mem[$past(wr_ptr_q)] == $past(cif.result))
    else $error("result not stored");
  wake_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_09]
    cif.done && sleep_mode && done_mask_q |=> wake_req ##1 !wake_req)
    else $error("no wake on completion");
  auto_off_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_10]
    cif.done && sleep_mode && !done_mask_q && on_q && !ctrl_wr |=> auto_off_q && on_q ##1 !analog_pwr_en)
    else $error("masked completion did not power off");
  idle_run_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_11]
    idle_mode && !sidl_q && !sleep_mode && on_q && !auto_off_q |=> conversion_in_progress_clk_en)
    else $error("idle stopped converter");
  reset_off_a: assert property (@(posedge ref_clk) // [RULE_12]
    rst |=> !on_q && !conversion_in_progress_q && !auto_off_q ##1 !analog_pwr_en)
    else $error("reset left converter on");
  uint_read_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_16]
    accept && !hwrite && form_q == FMT_UINT && acc_ofs == RES_BASE_OFS |=> hrdata[15:12] == 4'h0)
    else $error("unsigned read not zero extended");
  flag_set_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_08]
    cif.done |=> done_flag_q)
    else $error("completion lost its done flag");
  wake_awake_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_09]
    !sleep_mode |=> !wake_req)
    else $error("wake request while awake");
  auto_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_10]
    auto_off_q && !ctrl_wr |=> auto_off_q && !analog_pwr_en)
    else $error("auto power-off released early");
  idle_clk_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_11]
    idle_mode && sidl_q |=> !conversion_in_progress_clk_en)
    else $error("clock running in stopped idle");
  idle_abort_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_11]
    idle_mode && sidl_q && conversion_in_progress_q |=> !conversion_in_progress_q && !cif.busy)
    else $error("conversion survived stopped idle");
  off_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // [RULE_02]
    !on_q |=> !cif.busy && !cif.done)
    else $error("sequencer running while off");
endmodule

// [test/test_adc_power_ctrl.sv]
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module test_adc_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_pkg::*;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [RES_W-1:0] analog_code = 12'h000;
  logic hreadyout, hresp, analog_pwr_en, conversion_in_progress_clk_en, wake_req, irq;
  logic [11:0] mb[16];
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'h3E19;
  int wakes = 0;
  int ptr = 0;
  int n;
  int lat[2];

  always #2.5 ref_clk = ~ref_clk;

  // count wake pulses so a missing or doubled one shows up
  always @(posedge ref_clk) if (wake_req === 1'b1) wakes++;

  // short conversion counts keep the run brief
  adc_power_ctrl #(.DEPTH(16), .CONVERSION_IN_PROGRESS_CYCLES(8), .DELAY_CYCLES(2)) dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_mode(sleep_mode), .idle_mode(idle_mode), .analog_code(analog_code),
    .analog_pwr_en(analog_pwr_en), .conversion_in_progress_clk_en(conversion_in_progress_clk_en), .wake_req(wake_req), .irq(irq));

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // one single transfer; waits on the slave rather than assuming zero wait
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // reference formatting, offset binary for the signed forms
  function automatic logic [31:0] fmt(input int f, input logic [11:0] r);
    case (f)
      0: fmt = {20'h0, r};
      1: fmt = {16'h0, {4{~r[11]}}, ~r[11], r[10:0]};
      2: fmt = {16'h0, r, 4'h0};
      default: fmt = {16'h0, ~r[11], r[10:0], 4'h0};
    endcase
  endfunction

  // read one buffer entry in all four formats
  task automatic rd_res(input int i);
    for (int f = 0; f < 4; f++) begin
      wr(CTRL_OFS, 32'h1 | 32'(f << 4));
      chk_rd(RES_BASE_OFS + 12'(4 * i), fmt(f, mb[i]));
    end
  endtask

  // random code held steady so the synchroniser has settled by the end
  task automatic conversion_in_progress(input logic [31:0] c);
    logic [11:0] v;
    v = 12'($random(seed));
    analog_code <= v;
    mb[ptr] = v;
    ptr = (ptr + 1) % 16;
    cyc(3);
    wr(CTRL_OFS, c);
  endtask

  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 100) begin
      @(posedge ref_clk);
      c++;
    end
    `CHK(irq, 1'b1)
  endtask

  initial begin
    cyc(20000);
    num_errors++;
    end_of_test;
  end

  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    `CHK({analog_pwr_en, conversion_in_progress_clk_en, wake_req, irq}, 4'h0)
    foreach (lat[j]) lat[j] = 0;
    chk_rd(CTRL_OFS, 32'h0);
    chk_rd(STAT_OFS, 32'h0);
    chk_rd(IRQ_STAT_OFS, 32'h0);
    chk_rd(IRQ_MASK_OFS, 32'h0);
    chk_rd(12'h020, 32'h0);
    wr(CTRL_OFS, 32'h1);
    cyc(20); // settle time after power-up
    `CHK({analog_pwr_en, conversion_in_progress_clk_en}, 2'h3)
    wr(IRQ_MASK_OFS, 32'h1);
    // rc select alternates, so its start delay shows as a latency difference
    for (int k = 0; k < 4; k++) begin
      conversion_in_progress(32'h101 | 32'(2 * (k % 2)));
      wait_irq(lat[k % 2]);
      chk_rd(STAT_OFS, 32'h2);
      chk_rd(IRQ_STAT_OFS, 32'h1);
      wr(IRQ_STAT_OFS, 32'h1);
      chk_rd(IRQ_STAT_OFS, 32'h0);
      `CHK(irq, 1'b0)
      rd_res(k);
    end
    `CHK(lat[1] - lat[0], 2)
    // sleep in mid-conversion on the system clock
    wr(CTRL_OFS, 32'h101);
    cyc(3);
    sleep_mode <= 1'b1;
    cyc(3);
    `CHK(conversion_in_progress_clk_en, 1'b0)
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK({rd[2], rd[0]}, 2'b10)
    chk_rd(CTRL_OFS, 32'h1);
    sleep_mode <= 1'b0;
    cyc(30);
    chk_rd(IRQ_STAT_OFS, 32'h0);
    chk_rd(CTRL_OFS, 32'h1);
    // rc clock through sleep with the interrupt enabled
    conversion_in_progress(32'h103);
    sleep_mode <= 1'b1;
    n = wakes;
    wait_irq(lat[0]);
    cyc(2);
    `CHK(wakes - n, 1)
    `CHK(conversion_in_progress_clk_en, 1'b1)
    sleep_mode <= 1'b0;
    wr(IRQ_STAT_OFS, 32'h1);
    rd_res(ptr - 1);
    // same with the interrupt masked: silent power-off
    wr(IRQ_MASK_OFS, 32'h0);
    conversion_in_progress(32'h103);
    sleep_mode <= 1'b1;
    n = wakes;
    cyc(40);
    `CHK(analog_pwr_en, 1'b0)
    `CHK(wakes - n, 0)
    `CHK(irq, 1'b0)
    chk_rd(CTRL_OFS, 32'h3);
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK({rd[4], rd[0]}, 2'b10)
    chk_rd(IRQ_STAT_OFS, 32'h1);
    sleep_mode <= 1'b0;
    wr(IRQ_STAT_OFS, 32'h1);
    rd_res(ptr - 1);
    // idle halts only with stop_in_idle set
    wr(CTRL_OFS, 32'h105);
    cyc(3);
    idle_mode <= 1'b1;
    cyc(20);
    `CHK(conversion_in_progress_clk_en, 1'b0)
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK({rd[3], rd[0]}, 2'b10)
    chk_rd(IRQ_STAT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h1);
    cyc(3);
    `CHK(conversion_in_progress_clk_en, 1'b1)
    conversion_in_progress(32'h101);
    cyc(40);
    chk_rd(IRQ_STAT_OFS, 32'h1);
    idle_mode <= 1'b0;
    wr(IRQ_STAT_OFS, 32'h1);
    rd_res(ptr - 1);
    // reset in mid-conversion: registers cleared, buffer kept
    wr(CTRL_OFS, 32'h101);
    cyc(3);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    `CHK({analog_pwr_en, conversion_in_progress_clk_en, irq}, 3'h0)
    chk_rd(CTRL_OFS, 32'h0);
    chk_rd(STAT_OFS, 32'h0);
    cyc(30);
    chk_rd(IRQ_STAT_OFS, 32'h0);
    for (int i = 0; i < ptr; i++) rd_res(i);
    // start request while off is ignored
    wr(CTRL_OFS, 32'h100);
    cyc(20);
    `CHK({analog_pwr_en, conversion_in_progress_clk_en}, 2'h0)
    chk_rd(STAT_OFS, 32'h0);
    chk_rd(IRQ_STAT_OFS, 32'h0);
    end_of_test;
  end
endmodule
